// >>> core/dmm_map.svh
// Address map, field and size constants for the data memory map block
`ifndef DMM_MAP_SVH
`define DMM_MAP_SVH
`define DMM_RAM_BYTES 256
`define DMM_UPPER_BASE 8'h80
`define DMM_BANK_TOP 8'h1F
`define DMM_BIT_BASE 8'h20
`define DMM_BIT_TOP 8'h2F
`define DMM_SFS_BYTES 128
`define DMM_SECTOR_BYTES 512
`define DMM_FLASH_8K 16'h2000
`define DMM_FLASH_4K 16'h1000
`define DMM_FLASH_2K 16'h0800
`define DMM_PSW_BANK_LSB 3
`define DMM_ERASE_VALUE 8'hFF
`endif

// >>> core/dmm_pkg.sv
// Types shared by the data memory map block
package dmm_pkg;
    typedef enum logic [1:0] {DMM_DIRECT, DMM_INDIRECT, DMM_REGOP, DMM_BITOP} dmm_mode_t;
    typedef enum logic [1:0] {DMM_SZ_8K, DMM_SZ_4K, DMM_SZ_2K} dmm_size_t;
    typedef enum logic [1:0] {DMM_TGT_RAM, DMM_TGT_SFS, DMM_TGT_NONE} dmm_tgt_t;
endpackage : dmm_pkg

// >>> core/dmm_dec_if.sv
// Decoded data access passed from the top to the data RAM
`timescale 1ns/1ps
`default_nettype none
interface dmm_dec_if;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctl (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface : dmm_dec_if
`default_nettype wire

// >>> core/dmm_ram.sv
// Internal data RAM array
`timescale 1ns/1ps
`default_nettype none
`include "dmm_map.svh"
module dmm_ram #(
    parameter int DEPTH = `DMM_RAM_BYTES
) (
    input wire logic i_clk,     // System clock
    dmm_dec_if.mem port         // Decoded access
);
    logic [7:0] mem_r [DEPTH];

    // No reset on the array, contents hold across reset
    always_ff @(posedge i_clk) begin
        if (port.we) begin
            mem_r[port.addr] <= port.wdata;
        end
    end

    // Asynchronous read, the top registers the result
    assign port.rdata = mem_r[port.addr];
endmodule : dmm_ram
`default_nettype wire

// >>> core/dmm_top.sv
// Data and program memory address decoder
// Function
// - Provide 256 bytes of internal data RAM addressed by an 8-bit data address.
// - Indirect accesses to addresses 0x80 and up reach the upper 128 RAM bytes.
// - Direct accesses to addresses 0x80 and up go to the 128-entry special function space.
// - Addresses below 0x80 are served from RAM for direct and indirect accesses alike.
// - The lowest 32 RAM bytes form four register banks that register operands map onto.
// - The 16 bytes after the banks are reachable as bytes and as single bits.
// - Flash program space is 8k, 4k or 2k bytes depending on the variant.
// - Flash is erased in-system in 512-byte sectors with no external voltage.
`timescale 1ns/1ps
`default_nettype none
`include "dmm_map.svh"
module dmm_top
    import dmm_pkg::*;
#(
    parameter dmm_size_t FLASH_SIZE = DMM_SZ_8K
) (
    input wire logic I_SYS_CLK,             // System clock, 100 MHz
    input wire logic I_RESETN,              // Async reset, active low
    input wire logic I_D_REQ,               // Data access request
    input wire logic I_D_WE,                // Data write, else read
    input wire dmm_mode_t I_D_MODE,         // Addressing mode
    input wire logic [7:0] I_D_ADDR,        // Data address / reg no / bit no
    input wire logic [7:0] I_D_WDATA,       // Write data
    input wire logic I_D_BIT_WVAL,          // Bit write value
    input wire logic [7:0] I_PSW,           // Processor status word
    input wire logic [7:0] I_SFS_RDATA,     // Special function read data
    output logic O_SFS_REQ,                 // Special function strobe
    output logic O_SFS_WE,                  // Special function write
    output logic [6:0] O_SFS_ADDR,          // Special function index
    output logic [7:0] O_SFS_WDATA,         // Special function write data
    output logic O_D_VALID,                 // Data answer pulse
    output logic [7:0] O_D_RDATA,           // Data read byte, bit in b0
    input wire logic I_P_REQ,               // Program fetch or flash op
    input wire logic I_P_ERASE,             // Sector erase command
    input wire logic I_P_WE,                // Flash byte write command
    input wire logic [15:0] I_P_ADDR,       // Program address
    input wire logic [7:0] I_P_WDATA,       // Flash write data
    output logic O_P_VALID,                 // Program answer pulse
    output logic [7:0] O_P_RDATA,           // Program read data
    output logic O_P_ERR,                   // Access outside user flash
    output logic O_BUSY                     // Erase in progress
);
    localparam int FLASH_BYTES = (FLASH_SIZE == DMM_SZ_8K) ? `DMM_FLASH_8K :
                                 (FLASH_SIZE == DMM_SZ_4K) ? `DMM_FLASH_4K : `DMM_FLASH_2K;
    // top sector reserved on the largest part
    localparam int USER_BYTES = (FLASH_SIZE == DMM_SZ_8K) ? FLASH_BYTES - `DMM_SECTOR_BYTES : FLASH_BYTES;
    localparam int SEC_W = $clog2(`DMM_SECTOR_BYTES);
    localparam int FA_W = $clog2(FLASH_BYTES);

    dmm_dec_if ram_if ();
    dmm_ram #(.DEPTH(`DMM_RAM_BYTES)) u_ram (.i_clk(I_SYS_CLK), .port(ram_if));

    // Bit number to RAM byte address inside the bit area
    function automatic logic [7:0] bit_byte(input logic [7:0] bitno);
        bit_byte = `DMM_BIT_BASE + {4'h0, bitno[6:3]};
    endfunction : bit_byte

    // Data decode
    dmm_tgt_t tgt;
    logic [7:0] ram_addr;
    logic rmw;
    always_comb begin
        tgt = DMM_TGT_RAM;
        ram_addr = I_D_ADDR;
        rmw = 1'b0;
        unique case (I_D_MODE)
            DMM_DIRECT: begin
                if (I_D_ADDR >= `DMM_UPPER_BASE) begin
                    tgt = DMM_TGT_SFS;
                end
            end
            // indirect upper half stays in RAM
            DMM_INDIRECT: begin
                tgt = DMM_TGT_RAM;
            end
            DMM_REGOP: begin
                ram_addr = {3'h0, I_PSW[`DMM_PSW_BANK_LSB+1:`DMM_PSW_BANK_LSB], I_D_ADDR[2:0]};
            end
            // bit view of bytes 0x20..0x2F, upper bits are special function bits
            DMM_BITOP: begin
                if (I_D_ADDR[7]) begin
                    tgt = DMM_TGT_SFS;
                    ram_addr = {1'b1, I_D_ADDR[6:3], 3'h0};
                end else begin
                    ram_addr = bit_byte(I_D_ADDR);
                    rmw = I_D_WE;
                end
            end
        endcase
    end

    // Bit write needs read-modify-write of the RAM byte
    logic [7:0] merged;
    always_comb begin
        merged = ram_if.rdata;
        merged[I_D_ADDR[2:0]] = I_D_BIT_WVAL;
    end

    assign ram_if.addr = ram_addr;
    assign ram_if.we = I_D_REQ & I_D_WE & (tgt == DMM_TGT_RAM);
    assign ram_if.wdata = rmw ? merged : I_D_WDATA;

    // Special function strobes, one cycle after request
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_SFS_REQ <= 1'b0;
            O_SFS_WE <= 1'b0;
            O_SFS_ADDR <= 7'h00;
            O_SFS_WDATA <= 8'h00;
        end else begin
            O_SFS_REQ <= I_D_REQ & (tgt == DMM_TGT_SFS);
            O_SFS_WE <= I_D_REQ & I_D_WE & (tgt == DMM_TGT_SFS) & (I_D_MODE == DMM_DIRECT);
            O_SFS_ADDR <= ram_addr[6:0];
            O_SFS_WDATA <= I_D_WDATA;
        end
    end

    // RAM answer registered, special function answer follows one cycle later
    logic sfs_pend_r;
    logic bit_pend_r;
    logic [2:0] bit_sel_r;
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            sfs_pend_r <= 1'b0;
            bit_pend_r <= 1'b0;
            bit_sel_r <= 3'h0;
            O_D_VALID <= 1'b0;
            O_D_RDATA <= 8'h00;
        end else begin
            sfs_pend_r <= I_D_REQ & (tgt == DMM_TGT_SFS);
            bit_pend_r <= I_D_MODE == DMM_BITOP;
            bit_sel_r <= I_D_ADDR[2:0];
            O_D_VALID <= (I_D_REQ & (tgt == DMM_TGT_RAM)) | sfs_pend_r;
            if (sfs_pend_r) begin
                O_D_RDATA <= bit_pend_r ? {7'h00, I_SFS_RDATA[bit_sel_r]} : I_SFS_RDATA;
            end else if (I_D_MODE == DMM_BITOP) begin
                O_D_RDATA <= {7'h00, ram_if.rdata[I_D_ADDR[2:0]]};
            end else begin
                O_D_RDATA <= ram_if.rdata;
            end
        end
    end

    logic [7:0] flash_r [FLASH_BYTES];
    logic [FA_W-1:0] fa;
    logic in_user;
    assign fa = I_P_ADDR[FA_W-1:0];
    assign in_user = 32'(I_P_ADDR) < USER_BYTES;

    // sector erase walks one byte per cycle
    logic [FA_W-1:0] er_ptr_r;
    logic [SEC_W-1:0] er_cnt_r;
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_BUSY <= 1'b0;
            er_ptr_r <= '0;
            er_cnt_r <= '0;
        end else if (O_BUSY) begin
            er_ptr_r <= er_ptr_r + 1'b1;
            er_cnt_r <= er_cnt_r + 1'b1;
            if (&er_cnt_r) begin
                O_BUSY <= 1'b0;
            end
        end else if (I_P_REQ && I_P_ERASE && in_user) begin
            O_BUSY <= 1'b1;
            er_ptr_r <= {fa[FA_W-1:SEC_W], {SEC_W{1'b0}}};
            er_cnt_r <= '0;
        end
    end

    // Flash contents, erase to all ones; writes only clear bits
    always_ff @(posedge I_SYS_CLK) begin
        if (O_BUSY) begin
            flash_r[er_ptr_r] <= `DMM_ERASE_VALUE;
        end else if (I_P_REQ && I_P_WE && !I_P_ERASE && in_user) begin
            flash_r[fa] <= flash_r[fa] & I_P_WDATA;
        end
    end

    // Program answers; requests during erase are dropped
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_P_VALID <= 1'b0;
            O_P_RDATA <= 8'h00;
            O_P_ERR <= 1'b0;
        end else begin
            O_P_VALID <= I_P_REQ & ~O_BUSY;
            // reserved sector and beyond flag an error
            O_P_ERR <= I_P_REQ & ~O_BUSY & ~in_user;
            O_P_RDATA <= (in_user && !O_BUSY) ? flash_r[fa] : 8'h00;
        end
    end

    // a_direct_upper_sfs
    a_direct_upper_sfs: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        I_D_REQ && I_D_MODE == DMM_DIRECT && I_D_ADDR[7] |=> O_SFS_REQ && O_SFS_ADDR == $past(I_D_ADDR[6:0]))
        else $error("direct upper access missed special space");
    // a_indirect_upper_ram
    a_indirect_upper_ram: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        I_D_REQ && I_D_MODE == DMM_INDIRECT |=> !O_SFS_REQ && O_D_VALID)
        else $error("indirect access left RAM");
    // a_lower_ram
    a_lower_ram: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        I_D_REQ && !I_D_ADDR[7] && I_D_MODE inside {DMM_DIRECT, DMM_INDIRECT} |-> ram_if.addr == I_D_ADDR)
        else $error("lower address not served by RAM");
    // a_bank_select
    a_bank_select: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        I_D_MODE == DMM_REGOP |-> ram_if.addr <= `DMM_BANK_TOP && ram_if.addr[4:3] == I_PSW[4:3])
        else $error("register operand outside bank");
    // a_bit_area
    a_bit_area: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        I_D_MODE == DMM_BITOP && !I_D_ADDR[7] |-> ram_if.addr >= `DMM_BIT_BASE && ram_if.addr <= `DMM_BIT_TOP)
        else $error("bit address outside bit area");
    // a_data_answer
    a_data_answer: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        I_D_REQ && !O_SFS_REQ |-> ##[1:2] O_D_VALID)
        else $error("data answer missing");
    // a_erase_len
    a_erase_len: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        $rose(O_BUSY) |-> er_cnt_r == '0 ##1 (O_BUSY && er_cnt_r != '0) [*8])
        else $error("erase ended too soon");
    // a_reserved_err
    a_reserved_err: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        I_P_REQ && !O_BUSY && 32'(I_P_ADDR) >= USER_BYTES |=> O_P_ERR && O_P_VALID)
        else $error("reserved flash not flagged");
    // a_busy_drop
    a_busy_drop: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        O_BUSY |=> !O_P_VALID)
        else $error("answer given during erase");
endmodule : dmm_top
`default_nettype wire

// >>> tb/dmm_sfs_model.sv
// Special function space responder standing in for the peripheral registers
`timescale 1ns/1ps
`default_nettype none
module dmm_sfs_model (
    input wire logic i_clk,         // System clock
    input wire logic i_req,         // Access strobe
    input wire logic i_we,          // Write strobe
    input wire logic [6:0] i_addr,  // Register index
    input wire logic [7:0] i_wdata, // Write byte
    output logic [7:0] o_rdata      // Read byte
);
    logic [7:0] regs_r [0:127];
    logic [7:0] last_r;
    // answer while addressed, else the inverse of the last byte so stale data never matches
    always_comb o_rdata = i_req ? regs_r[i_addr] : ~last_r;
    // Known contents so a read through the decoder can be compared exactly
    initial begin
        last_r = 8'h00;
        for (int i = 0; i < 128; i++) begin
            regs_r[i] = 8'h80 ^ 8'(i);
        end
    end
    // Writes land at the strobe edge
    always @(posedge i_clk) begin
        if (i_req && i_we) begin
            regs_r[i_addr] <= i_wdata;
        end
        if (i_req) begin
            last_r <= regs_r[i_addr];
        end
    end
endmodule : dmm_sfs_model
`default_nettype wire

// >>> tb/dmm_top_tb_top.sv
// Self-checking bench for the data and program memory decoder
`timescale 1ns/1ps
`default_nettype none
module dmm_top_tb_top;
    import dmm_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, d_req = 1'b0, d_we = 1'b0, d_bit = 1'b0;
    logic p_req = 1'b0, p_erase = 1'b0, p_we = 1'b0;
    dmm_mode_t d_mode = DMM_DIRECT;
    logic [7:0] d_addr = 8'h00, d_wdata = 8'h00, psw = 8'h00, p_wdata = 8'h00;
    logic [15:0] p_addr = 16'h0000;
    logic sfs_req, sfs_we, d_valid, p_valid, p_err, busy, sfs_seen, err;
    logic [6:0] sfs_addr, sfs_idx;
    logic [7:0] sfs_rdata, sfs_wdata, d_rdata, p_rdata, rd;
    int miscompares = 0;
    int checks_done = 0;
    // Free-running system clock, 10 ns period
    always #5 clk = ~clk;
    dmm_top #(.FLASH_SIZE(DMM_SZ_8K)) dut (.I_SYS_CLK(clk), .I_RESETN(rst_n), .I_D_REQ(d_req), .I_D_WE(d_we),
        .I_D_MODE(d_mode), .I_D_ADDR(d_addr), .I_D_WDATA(d_wdata), .I_D_BIT_WVAL(d_bit), .I_PSW(psw),
        .I_SFS_RDATA(sfs_rdata), .O_SFS_REQ(sfs_req), .O_SFS_WE(sfs_we), .O_SFS_ADDR(sfs_addr),
        .O_SFS_WDATA(sfs_wdata), .O_D_VALID(d_valid), .O_D_RDATA(d_rdata), .I_P_REQ(p_req),
        .I_P_ERASE(p_erase), .I_P_WE(p_we), .I_P_ADDR(p_addr), .I_P_WDATA(p_wdata), .O_P_VALID(p_valid),
        .O_P_RDATA(p_rdata), .O_P_ERR(p_err), .O_BUSY(busy));
    dmm_sfs_model sfs (.i_clk(clk), .i_req(sfs_req), .i_we(sfs_we), .i_addr(sfs_addr), .i_wdata(sfs_wdata),
        .o_rdata(sfs_rdata));
    // Verdict and end of run
    task automatic wrap_up();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // One data access; the wait is bounded so a missing answer ends the run
    task automatic d_acc(input dmm_mode_t m, input logic we, input logic [7:0] a, input logic [7:0] wd,
                         input logic bv);
        int n;
        n = 0;
        sfs_seen = 1'b0;
        @(posedge clk);
        d_req <= 1'b1;
        d_mode <= m;
        {d_we, d_addr, d_wdata, d_bit} <= {we, a, wd, bv};
        @(posedge clk);
        d_req <= 1'b0;
        do begin
            @(negedge clk);
            n++;
            if (sfs_req === 1'b1) begin
                sfs_seen = 1'b1;
                sfs_idx = sfs_addr;
            end
        end while (d_valid !== 1'b1 && n < 8);
        if (d_valid !== 1'b1) begin
            miscompares++;
            wrap_up();
        end
        rd = d_rdata;
    endtask : d_acc
    // One program access, requests to the reserved sector and beyond are issued here too
    task automatic p_acc(input logic er, input logic we, input logic [15:0] a, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        p_req <= 1'b1;
        {p_erase, p_we, p_addr, p_wdata} <= {er, we, a, wd};
        @(posedge clk);
        p_req <= 1'b0;
        do begin
            @(negedge clk);
            n++;
        end while (p_valid !== 1'b1 && n < 8);
        if (p_valid !== 1'b1) begin
            miscompares++;
            wrap_up();
        end
        {err, rd} = {p_err, p_rdata};
    endtask : p_acc
    task automatic t_lower_upper();
        d_acc(DMM_DIRECT, 1'b1, 8'h7F, 8'h3C, 1'b0);
        d_acc(DMM_INDIRECT, 1'b0, 8'h7F, 8'h00, 1'b0);
        chk(rd, 8'h3C);
        d_acc(DMM_INDIRECT, 1'b1, 8'h90, 8'hC3, 1'b0);
        d_acc(DMM_DIRECT, 1'b0, 8'h90, 8'h00, 1'b0);
        chk({sfs_seen, sfs_idx, rd}, {1'b1, 7'h10, 8'h90});
        d_acc(DMM_INDIRECT, 1'b0, 8'h90, 8'h00, 1'b0);
        chk({sfs_seen, rd}, {1'b0, 8'hC3});
        // Special space write must land there and leave the RAM byte alone
        d_acc(DMM_DIRECT, 1'b1, 8'h90, 8'hA5, 1'b0);
        d_acc(DMM_DIRECT, 1'b0, 8'h90, 8'h00, 1'b0);
        chk({sfs_seen, sfs_idx, rd}, {1'b1, 7'h10, 8'hA5});
        d_acc(DMM_INDIRECT, 1'b0, 8'h90, 8'h00, 1'b0);
        chk({sfs_seen, rd}, {1'b0, 8'hC3});
        d_acc(DMM_INDIRECT, 1'b1, 8'hFF, 8'h5E, 1'b0);
        d_acc(DMM_INDIRECT, 1'b0, 8'hFF, 8'h00, 1'b0);
        chk(rd, 8'h5E);
        $display("test lower_upper done");
    endtask : t_lower_upper
    task automatic t_banks();
        for (int b = 0; b < 4; b++) begin
            @(posedge clk);
            psw <= {3'h0, 2'(b), 3'h0};
            d_acc(DMM_REGOP, 1'b1, 8'h05, 8'h60 + 8'(b), 1'b0);
            d_acc(DMM_DIRECT, 1'b0, 8'(b * 8 + 5), 8'h00, 1'b0);
            chk(rd, 8'h60 + 8'(b));
        end
        $display("test banks done");
    endtask : t_banks
    task automatic t_bits();
        d_acc(DMM_DIRECT, 1'b1, 8'h2F, 8'h00, 1'b0);
        d_acc(DMM_BITOP, 1'b1, 8'h7E, 8'h00, 1'b1);
        d_acc(DMM_DIRECT, 1'b0, 8'h2F, 8'h00, 1'b0);
        chk(rd, 8'h40);
        d_acc(DMM_BITOP, 1'b0, 8'h7E, 8'h00, 1'b0);
        chk(rd, 8'h01);
        // Bit numbers 0x80 and up read bits of special space bytes
        d_acc(DMM_BITOP, 1'b0, 8'h8B, 8'h00, 1'b0);
        chk({sfs_seen, sfs_idx, rd}, {1'b1, 7'h08, 8'h01});
        d_acc(DMM_BITOP, 1'b0, 8'h8C, 8'h00, 1'b0);
        chk(rd, 8'h00);
        $display("test bits done");
    endtask : t_bits
    task automatic t_flash();
        int n;
        n = 0;
        p_acc(1'b1, 1'b0, 16'h0200, 8'h00);
        // The answer's own cycle already shows busy, count it too
        n = int'(busy === 1'b1);
        repeat (600) begin
            @(negedge clk);
            n += int'(busy === 1'b1);
        end
        chk(16'(n), 16'h0200);
        p_acc(1'b0, 1'b0, 16'h03FF, 8'h00);
        chk({err, rd}, {1'b0, 8'hFF});
        p_acc(1'b0, 1'b1, 16'h03FF, 8'h5A);
        p_acc(1'b0, 1'b1, 16'h03FF, 8'h0F);
        p_acc(1'b0, 1'b0, 16'h03FF, 8'h00);
        chk({err, rd}, {1'b0, 8'h0A});
        p_acc(1'b0, 1'b0, 16'h1DFF, 8'h00);
        chk(err, 1'b0);
        p_acc(1'b1, 1'b0, 16'h1E00, 8'h00);
        chk({err, busy}, {1'b1, 1'b0});
        p_acc(1'b0, 1'b0, 16'h1E00, 8'h00);
        chk({err, rd}, {1'b1, 8'h00});
        p_acc(1'b0, 1'b0, 16'h2000, 8'h00);
        chk(err, 1'b1);
        $display("test flash done");
    endtask : t_flash
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_lower_upper();
        t_banks();
        t_bits();
        t_flash();
        wrap_up();
    end
endmodule : dmm_top_tb_top
`default_nettype wire
